/* File: include/ots_pkg.sv */
// Purpose: Shared constants and types of the output transient sequencer.
// Assumes: Byte-wide register addresses on the plain command port.
// Notes: Currents in 0.1 A units, voltages in 0.1 V units, times in ticks.
package ots_pkg;
   localparam int NSET = 6;
   localparam int NPT = 32;
   localparam int VW = 16;
   localparam int TW = 24;
   localparam logic [7:0] A_CMD = 8'h00;
   localparam logic [7:0] A_CFG = 8'h01;
   localparam logic [7:0] A_STAT = 8'h02;
   localparam logic [7:0] A_RANGE = 8'h03;
   localparam logic [7:0] A_CURR = 8'h04;
   localparam logic [7:0] A_MODE = 8'h05;
   localparam logic [7:0] A_PCNT = 8'h06;
   localparam logic [7:0] A_PPER = 8'h07;
   localparam logic [7:0] A_PDUTY = 8'h08;
   localparam logic [7:0] A_PWID = 8'h09;
   localparam logic [7:0] A_LCNT = 8'h0A;
   localparam logic [7:0] A_DWELL = 8'h0B;
   localparam logic [7:0] A_IMM = 8'h10;
   localparam logic [7:0] A_TRIG = 8'h18;
   localparam logic [7:0] A_LIST = 8'h20;
   localparam int C_ARM = 0;
   localparam int C_ABORT = 1;
   localparam int C_GRST = 2;
   localparam int C_DCLR = 3;
   localparam int C_TRIG = 4;
   localparam int C_SAVE = 5;
   localparam int C_LCLR = 6;
   localparam int F_CONT = 0;
   localparam int F_ONCE = 1;
   localparam int S_ERR = 0;
   localparam int S_RAN = 1;
   localparam int S_ST = 8;
   localparam logic [1:0] M_FIXED = 2'h0;
   localparam logic [1:0] M_STEP = 2'h1;
   localparam logic [1:0] M_PULSE = 2'h2;
   localparam logic [1:0] M_LIST = 2'h3;
   localparam logic [15:0] CUR_HI_MAX = 16'h0050;
   localparam logic [15:0] LCNT_RST = 16'h0001;
   localparam logic [7:0] PCT_FULL = 8'h64;
   localparam int CLK_NS = 8;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [5:0] {
      OTS_IDLE = 6'h01,
      OTS_ARMED = 6'h02,
      OTS_PHI = 6'h04,
      OTS_PLO = 6'h08,
      OTS_DWELL = 6'h10,
      OTS_LWAIT = 6'h20
   } ots_state_e;
   typedef logic [NSET-1:0][VW-1:0] ots_vals_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ots_bus_s;
endpackage : ots_pkg

/* File: core/ots_core.sv */
// Purpose: Range/current coupling checks and output transient sequencing.
// Assumes: Command port on the same clock; lists_local from local logic.
// Notes: Slot 0..5 = AC volt, DC volt, frequency, phase, volt slew, freq slew.
// Operation
// - Reject current limit above range maximum
// - Range change clamps current, high max 8.0A
// - Range and current checked in arrival order
// - Arming checks transient voltages against rms maximum
// - Six settings are under transient control
// - Modes: step, pulse, list or fixed
// - General reset or clear forces fixed modes
// - Trigger applies triggered value; step commits it
// - Pulse reverts low phase and after last
// - Finished list holds its last values
// - Mixed transient modes across settings rejected
// - Pulse count, period, duty or width
// - Arming needed; one arming, one transient
// - Lists of 32 points, hold, count, advance
// - Save bus list only after it ran
// - Points output in order, each held
// - Unequal list lengths error; single entry expands
// - Hold list matches points or single entry
// - List repeats count times, reset count 1
// - Timed advance is default, next immediately
// - Trigger advance moves one point per trigger
// - Triggers during hold time are discarded
// - Idle ignores triggers; abort forces idle
// - Completion returns idle unless continuous
// - Hold end: idle, wait armed, or next
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ots_core
   import ots_pkg::*;
#(
   parameter logic [15:0] CUR_LO_MAX = 16'h00A0,
   parameter logic [15:0] VRMS_MAX = 16'h0C30
) (
   input wire logic clk, // 125 MHz clock
   input wire logic rst_n, // Synchronous reset
   input wire ots_bus_s bus, // Command port request
   output logic [31:0] rdata, // Read data, cycle after read
   input wire logic lists_local, // Lists entered locally
   output ots_vals_t out_vals, // Active value of each setting
   output logic nv_save, // Pulse: store setup slot
   output logic cmd_err // Sticky error flag
);
   ots_state_e st_q;
   logic [15:0] cur_q;
   logic range_hi_q;
   logic [2*NSET-1:0] mode_q;
   logic [15:0] pcnt_q;
   logic [TW-1:0] pper_q;
   logic [TW-1:0] pwid_q;
   logic [7:0] pduty_q;
   logic wgiven_q;
   logic [15:0] lcnt_q;
   logic cont_q;
   logic once_q;
   logic err_q;
   logic ran_q;
   ots_vals_t imm_q;
   ots_vals_t trg_q;
   ots_vals_t lv_q;
   ots_vals_t out_q;
   logic [VW-1:0] list_q [NSET][NPT];
   logic [5:0] len_q [NSET];
   logic [TW-1:0] dwell_q [NPT];
   logic [5:0] dlen_q;
   logic [5:0] n_q;
   logic [4:0] pt_q;
   logic [15:0] rep_q;
   logic [15:0] pleft_q;
   logic [TW-1:0] tmr_q;
   logic [TW-1:0] w_q;
   logic lact_q;
   logic [7:0] div_q;
   logic [31:0] rdata_q;
   logic save_q;
   logic tick;
   logic cmd_wr;
   logic arm;
   logic abort;
   logic grst;
   logic clr;
   logic trig;
   logic save;
   logic lclr;
   logic [15:0] cur_max;
   logic cur_bad;
   logic mode_mix;
   logic [1:0] tkind;
   logic arm_bad;
   logic [5:0] n_c;
   logic [31:0] prod;
   logic [TW-1:0] w_c;
   logic exp;
   logic last_pt;
   logic seq_end;
   logic [4:0] nxt_pt;
   logic [4:0] lp;
   ots_vals_t pv;
   logic [TW-1:0] dw;
   ots_state_e done_st;
   logic list_wr;
   logic [2:0] lsel;
   logic list_full;
   logic dwell_full;
   logic duty_bad;
   logic err_set;

   assign cmd_wr = bus.wr && bus.addr == A_CMD;
   assign arm = cmd_wr && bus.wdata[C_ARM];
   assign abort = cmd_wr && bus.wdata[C_ABORT];
   assign grst = cmd_wr && bus.wdata[C_GRST];
   assign clr = grst || (cmd_wr && bus.wdata[C_DCLR]);
   assign trig = cmd_wr && bus.wdata[C_TRIG];
   assign save = cmd_wr && bus.wdata[C_SAVE];
   assign lclr = cmd_wr && bus.wdata[C_LCLR];
   assign list_wr = bus.wr && bus.addr >= A_LIST && bus.addr < A_LIST + 8'(NSET);
   assign lsel = 3'(bus.addr - A_LIST);
   assign list_full = list_wr && len_q[lsel] == 6'(NPT);
   assign dwell_full = bus.wr && bus.addr == A_DWELL && dlen_q == 6'(NPT);
   assign duty_bad = bus.wr && bus.addr == A_PDUTY && bus.wdata[7:0] > PCT_FULL;

   // Tick divider for hold and pulse timing
   always_ff @(posedge clk) begin
      if (!rst_n || div_q == 8'(TICK_CYC - 1)) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end
   assign tick = div_q == 8'(TICK_CYC - 1);

   // Range coupled current limit
   assign cur_max = range_hi_q ? CUR_HI_MAX : CUR_LO_MAX;
   assign cur_bad = bus.wr && bus.addr == A_CURR && bus.wdata[15:0] > cur_max;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         range_hi_q <= 1'b0;
         cur_q <= 16'h0000;
      end else if (bus.wr && bus.addr == A_RANGE) begin
         range_hi_q <= bus.wdata[0];
         if (bus.wdata[0] && cur_q > CUR_HI_MAX) begin
            cur_q <= CUR_HI_MAX;
         end
      end else if (bus.wr && bus.addr == A_CURR && !cur_bad) begin
         cur_q <= bus.wdata[15:0];
      end
   end

   // Mode mix check and active transient kind
   always_comb begin
      mode_mix = 1'b0;
      tkind = M_FIXED;
      for (int i = 0; i < NSET; i++) begin
         if (bus.wdata[2*i+:2] != M_FIXED) begin
            if (tkind != M_FIXED && tkind != bus.wdata[2*i+:2]) begin
               mode_mix = 1'b1;
            end
            tkind = bus.wdata[2*i+:2];
         end
      end
      tkind = M_FIXED;
      for (int i = 0; i < NSET; i++) begin
         if (mode_q[2*i+:2] != M_FIXED) begin
            tkind = mode_q[2*i+:2];
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n || clr) begin
         mode_q <= '0;
      end else if (bus.wr && bus.addr == A_MODE && !mode_mix) begin
         mode_q <= bus.wdata[2*NSET-1:0];
      end
   end

   // Pulse, list count and advance settings
   always_ff @(posedge clk) begin
      if (!rst_n || grst) begin
         pcnt_q <= 16'h0001;
         pper_q <= '0;
         pwid_q <= '0;
         pduty_q <= 8'h00;
         wgiven_q <= 1'b0;
         lcnt_q <= LCNT_RST;
         cont_q <= 1'b0;
         once_q <= 1'b0;
      end else if (bus.wr) begin
         case (bus.addr)
            A_PCNT: pcnt_q <= bus.wdata[15:0];
            A_PPER: pper_q <= bus.wdata[TW-1:0];
            A_PDUTY: begin
               if (!duty_bad) begin
                  pduty_q <= bus.wdata[7:0];
                  wgiven_q <= 1'b0;
               end
            end
            A_PWID: begin
               pwid_q <= bus.wdata[TW-1:0];
               wgiven_q <= 1'b1;
            end
            A_LCNT: lcnt_q <= bus.wdata[15:0];
            A_CFG: begin
               cont_q <= bus.wdata[F_CONT];
               once_q <= bus.wdata[F_ONCE];
            end
            default: begin
            end
         endcase
      end
   end
   assign prod = {8'h00, pper_q} * {24'h000000, pduty_q};
   assign w_c = wgiven_q ? pwid_q : TW'(prod / 32'(PCT_FULL));

   // Immediate and triggered values
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         imm_q <= '0;
         trg_q <= '0;
      end else begin
         for (int i = 0; i < NSET; i++) begin
            if (bus.wr && bus.addr == A_IMM + 8'(i)) begin
               imm_q[i] <= bus.wdata[VW-1:0];
            end
            if (bus.wr && bus.addr == A_TRIG + 8'(i)) begin
               trg_q[i] <= bus.wdata[VW-1:0];
            end
            if (st_q == OTS_ARMED && trig && tkind == M_STEP && mode_q[2*i+:2] == M_STEP) begin
               imm_q[i] <= trg_q[i];
            end
         end
      end
   end

   // Point and hold lists
   always_ff @(posedge clk) begin
      if (!rst_n || lclr) begin
         for (int i = 0; i < NSET; i++) begin
            len_q[i] <= 6'h00;
         end
         dlen_q <= 6'h00;
      end else begin
         if (list_wr && !list_full) begin
            list_q[lsel][len_q[lsel][4:0]] <= bus.wdata[VW-1:0];
            len_q[lsel] <= len_q[lsel] + 6'h01;
         end
         if (bus.wr && bus.addr == A_DWELL && !dwell_full) begin
            dwell_q[dlen_q[4:0]] <= bus.wdata[TW-1:0];
            dlen_q <= dlen_q + 6'h01;
         end
      end
   end

   // Checks made when the trigger system is armed
   always_comb begin
      arm_bad = 1'b0;
      n_c = 6'h01;
      for (int i = 0; i < NSET; i++) begin
         if (mode_q[2*i+:2] == M_LIST && len_q[i] > n_c) begin
            n_c = len_q[i];
         end
      end
      for (int i = 0; i < NSET; i++) begin
         if (mode_q[2*i+:2] == M_LIST && len_q[i] != n_c && len_q[i] != 6'h01) begin
            arm_bad = 1'b1;
         end
         if (i < 2 && mode_q[2*i+:2] != M_FIXED && mode_q[2*i+:2] != M_LIST && trg_q[i] > VRMS_MAX) begin
            arm_bad = 1'b1;
         end
         for (int k = 0; k < NPT; k++) begin
            if (i < 2 && mode_q[2*i+:2] == M_LIST && 6'(k) < len_q[i] && list_q[i][k] > VRMS_MAX) begin
               arm_bad = 1'b1;
            end
         end
      end
      if (tkind == M_LIST && dlen_q != n_c && dlen_q != 6'h01) begin
         arm_bad = 1'b1;
      end
      if (tkind == M_PULSE && w_c > pper_q) begin
         arm_bad = 1'b1;
      end
   end

   // Next point selection, single entries expanded
   assign last_pt = 6'(pt_q) + 6'h01 >= n_q;
   assign seq_end = last_pt && rep_q + 16'h0001 >= lcnt_q;
   assign nxt_pt = last_pt ? 5'h00 : pt_q + 5'h01;
   assign lp = st_q == OTS_ARMED ? 5'h00 : nxt_pt;
   always_comb begin
      for (int i = 0; i < NSET; i++) begin
         pv[i] = len_q[i] == 6'h01 ? list_q[i][0] : list_q[i][lp];
      end
      dw = dlen_q == 6'h01 ? dwell_q[0] : dwell_q[lp];
   end
   assign exp = tmr_q == '0;
   assign done_st = cont_q ? OTS_ARMED : OTS_IDLE;

   // Transient sequencer
   always_ff @(posedge clk) begin
      if (!rst_n || grst || clr) begin
         st_q <= OTS_IDLE;
         pt_q <= 5'h00;
         rep_q <= 16'h0000;
         pleft_q <= 16'h0000;
         tmr_q <= '0;
         w_q <= '0;
         n_q <= 6'h01;
         lact_q <= 1'b0;
         lv_q <= '0;
      end else if (abort) begin
         st_q <= OTS_IDLE;
      end else begin
         if (tick && !exp) begin
            tmr_q <= tmr_q - TW'(1);
         end
         case (st_q)
            OTS_IDLE: begin
               if (arm && !arm_bad) begin
                  st_q <= OTS_ARMED;
                  w_q <= w_c;
                  n_q <= n_c;
               end
            end
            OTS_ARMED: begin
               if (trig) begin
                  case (tkind)
                     M_PULSE: begin
                        st_q <= pcnt_q == 16'h0000 ? done_st : OTS_PHI;
                        tmr_q <= w_q;
                        pleft_q <= pcnt_q;
                     end
                     M_LIST: begin
                        st_q <= OTS_DWELL;
                        pt_q <= 5'h00;
                        rep_q <= 16'h0000;
                        tmr_q <= dw;
                        lact_q <= 1'b1;
                        lv_q <= pv;
                     end
                     default: st_q <= done_st;
                  endcase
               end
            end
            OTS_PHI: begin
               if (exp) begin
                  st_q <= OTS_PLO;
                  tmr_q <= pper_q - w_q;
               end
            end
            OTS_PLO: begin
               if (exp) begin
                  if (pleft_q > 16'h0001) begin
                     pleft_q <= pleft_q - 16'h0001;
                     st_q <= OTS_PHI;
                     tmr_q <= w_q;
                  end else begin
                     st_q <= done_st;
                  end
               end
            end
            OTS_DWELL: begin
               if (exp) begin
                  if (seq_end) begin
                     st_q <= done_st;
                  end else if (once_q) begin
                     st_q <= OTS_LWAIT;
                  end else begin
                     pt_q <= nxt_pt;
                     rep_q <= last_pt ? rep_q + 16'h0001 : rep_q;
                     tmr_q <= dw;
                     lv_q <= pv;
                  end
               end
            end
            OTS_LWAIT: begin
               if (trig) begin
                  st_q <= OTS_DWELL;
                  pt_q <= nxt_pt;
                  rep_q <= last_pt ? rep_q + 16'h0001 : rep_q;
                  tmr_q <= dw;
                  lv_q <= pv;
               end
            end
            default: st_q <= OTS_IDLE;
         endcase
         if (bus.wr && bus.addr == A_MODE && !mode_mix) begin
            lact_q <= 1'b0;
         end
      end
   end

   // Output value selection
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_q <= '0;
      end else begin
         for (int i = 0; i < NSET; i++) begin
            if (mode_q[2*i+:2] == M_PULSE && st_q == OTS_PHI) begin
               out_q[i] <= trg_q[i];
            end else if (mode_q[2*i+:2] == M_LIST && lact_q) begin
               out_q[i] <= lv_q[i];
            end else begin
               out_q[i] <= imm_q[i];
            end
         end
      end
   end

   // Sticky error; a new error wins over a clear
   assign err_set = cur_bad || (bus.wr && bus.addr == A_MODE && mode_mix) || list_full || dwell_full || duty_bad
                    || (arm && st_q == OTS_IDLE && arm_bad);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_q <= 1'b0;
      end else if (err_set) begin
         err_q <= 1'b1;
      end else if (bus.wr && bus.addr == A_STAT && bus.wdata[S_ERR]) begin
         err_q <= 1'b0;
      end
   end

   // Setup save gating
   always_ff @(posedge clk) begin
      if (!rst_n || lclr || list_wr || (bus.wr && bus.addr == A_DWELL)) begin
         ran_q <= 1'b0;
      end else if (st_q == OTS_DWELL) begin
         ran_q <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         save_q <= 1'b0;
      end else begin
         save_q <= save && (ran_q || lists_local);
      end
   end

   // Read port
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h00000000;
      end else if (bus.rd) begin
         rdata_q <= 32'h00000000;
         case (bus.addr)
            A_CFG: rdata_q <= {30'h0, once_q, cont_q};
            A_STAT: rdata_q <= {18'h0, st_q, 6'h0, ran_q, err_q};
            A_RANGE: rdata_q <= {31'h0, range_hi_q};
            A_CURR: rdata_q <= {16'h0, cur_q};
            A_MODE: rdata_q <= {20'h0, mode_q};
            A_PCNT: rdata_q <= {16'h0, pcnt_q};
            A_PPER: rdata_q <= {8'h0, pper_q};
            A_PDUTY: rdata_q <= {24'h0, pduty_q};
            A_PWID: rdata_q <= {8'h0, w_c};
            A_LCNT: rdata_q <= {16'h0, lcnt_q};
            default: begin
               for (int i = 0; i < NSET; i++) begin
                  if (bus.addr == A_IMM + 8'(i)) begin
                     rdata_q <= {16'h0, out_q[i]};
                  end
               end
            end
         endcase
      end
   end

   assign rdata = rdata_q;
   assign out_vals = out_q;
   assign nv_save = save_q;
   assign cmd_err = err_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_arm_fail;
      arm && st_q == OTS_IDLE && arm_bad;
   endsequence
   sequence s_err_idle;
      err_q && st_q == OTS_IDLE;
   endsequence

   a_cur_within: assert property (cur_q <= (range_hi_q ? CUR_HI_MAX : CUR_LO_MAX))
      else $error("current limit above range maximum");
   a_cur_reject: assert property (cur_bad |=> err_q && cur_q == $past(cur_q))
      else $error("over-range current applied");
   a_arm_fail: assert property (s_arm_fail |=> s_err_idle)
      else $error("failed arming not flagged");
   a_reset_fixed: assert property (grst |=> mode_q == '0 && st_q == OTS_IDLE && lcnt_q == LCNT_RST)
      else $error("general reset left transient state");
   a_idle_ignore: assert property (st_q == OTS_IDLE && !arm |=> st_q == OTS_IDLE)
      else $error("idle left without arming");
   a_step_commit: assert property (st_q == OTS_ARMED && trig && tkind == M_STEP && mode_q[1:0] == M_STEP
      && !grst && !abort |=> imm_q[0] == $past(trg_q[0]) ##1 out_q[0] == imm_q[0])
      else $error("step value not committed");
   a_mix_reject: assert property (bus.wr && bus.addr == A_MODE && mode_mix && !clr |=> $stable(mode_q) && err_q)
      else $error("mixed modes accepted");
   a_hold_discard: assert property (st_q == OTS_DWELL && !exp && trig && !abort && !clr |=> $stable(pt_q))
      else $error("trigger advanced during hold");
   a_once_idle: assert property (st_q == OTS_ARMED && trig && tkind == M_STEP && !cont_q && !clr && !abort
      |=> st_q == OTS_IDLE)
      else $error("single arming not spent");
   a_save_gate: assert property (save && !ran_q && !lists_local |=> !nv_save)
      else $error("unrun bus list saved");
endmodule : ots_core
`default_nettype wire

/* File: verification/ots_host.sv */
// Purpose: Host controller model for the command port.
// Assumes: One request per call, strobes one cycle long.
// Notes: Write data is inverted once released so stale data never matches.
`timescale 1ns/1ps
`default_nettype none
module ots_host
   import ots_pkg::*;
(
   input wire logic clk, // Device clock
   output var ots_bus_s bus, // Request to the device
   input wire logic [31:0] rdata // Read data from the device
);
   initial begin
      bus = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
      bus.wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd
   // One command bit per write; arming precedes every trigger it expects
   task automatic cmd(input int b);
      wr(A_CMD, 32'h1 << b);
   endtask : cmd
endmodule : ots_host
`default_nettype wire

/* File: verification/output_transient_sequencer_tb.sv */
// Purpose: Self-checking bench of the transient sequencer.
// Assumes: Tick of TICK_CYC clocks, one tick of timing slack.
// Notes: Local list entry is raised only for the last save check.
`timescale 1ns/1ps
`default_nettype none
module output_transient_sequencer_tb;
   import ots_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic lists_local = 1'b0;
   ots_bus_s bus;
   logic [31:0] rdata;
   ots_vals_t out_vals;
   logic nv_save;
   logic cmd_err;
   logic [31:0] d;
   int errors = 0;
   int checks = 0;
   int saves = 0;
   always #4 clk = ~clk;
   always @(posedge clk) if (nv_save === 1'b1) saves <= saves + 1;
   ots_core ots_core_i(.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .lists_local(lists_local),
      .out_vals(out_vals), .nv_save(nv_save), .cmd_err(cmd_err));
   ots_host ots_host_i(.clk(clk), .bus(bus), .rdata(rdata));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      ots_host_i.rd(a, d);
      chk(d, exp);
   endtask : rchk
   task automatic w(input logic [7:0] a, input logic [31:0] v);
      ots_host_i.wr(a, v);
   endtask : w
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc
   task automatic t_coupling();
      rchk(A_STAT, 32'h100);
      rchk(A_LCNT, 32'h1);
      w(A_RANGE, 32'h1);
      w(A_CURR, 32'h51);
      wait_cyc(1);
      chk(cmd_err, 1'b1);
      rchk(A_CURR, 32'h0);
      w(A_STAT, 32'h1);
      w(A_RANGE, 32'h0);
      w(A_CURR, 32'hA0);
      wait_cyc(1);
      chk(cmd_err, 1'b0);
      w(A_RANGE, 32'h1);
      rchk(A_CURR, 32'h50);
      chk(cmd_err, 1'b0);
   endtask : t_coupling
   task automatic t_step();
      w(A_IMM, 32'h100);
      w(A_MODE, 32'h1);
      w(A_TRIG, 32'h4B0);
      ots_host_i.cmd(C_TRIG);
      wait_cyc(3);
      chk(out_vals[0], 16'h100);
      ots_host_i.cmd(C_ARM);
      rchk(A_STAT, 32'h200);
      ots_host_i.cmd(C_TRIG);
      wait_cyc(3);
      chk(out_vals[0], 16'h4B0);
      rchk(A_STAT, 32'h100);
      w(A_MODE, 32'h0);
      rchk(A_IMM, 32'h4B0);
      w(A_MODE, 32'h9);
      wait_cyc(1);
      chk(cmd_err, 1'b1);
      rchk(A_MODE, 32'h0);
      w(A_STAT, 32'h1);
   endtask : t_step
   task automatic t_pulse();
      w(A_MODE, 32'h2);
      w(A_TRIG, 32'hC31);
      ots_host_i.cmd(C_ARM);
      rchk(A_STAT, 32'h101);
      w(A_STAT, 32'h1);
      w(A_TRIG, 32'h10);
      w(A_PCNT, 32'h1);
      w(A_PPER, 32'h4);
      w(A_PDUTY, 32'h65);
      rchk(A_STAT, 32'h101);
      w(A_STAT, 32'h1);
      w(A_PDUTY, 32'd50);
      rchk(A_PWID, 32'h2);
      ots_host_i.cmd(C_ARM);
      ots_host_i.cmd(C_TRIG);
      wait_cyc(TICK_CYC / 2);
      chk(out_vals[0], 16'h10);
      wait_cyc(6 * TICK_CYC);
      chk(out_vals[0], 16'h4B0);
      w(A_PWID, 32'h3);
      rchk(A_PWID, 32'h3);
   endtask : t_pulse
   task automatic t_list();
      w(A_MODE, 32'h3C);
      w(A_LIST + 8'h1, 32'h11);
      w(A_LIST + 8'h1, 32'h22);
      w(A_LIST + 8'h1, 32'h33);
      w(A_LIST + 8'h2, 32'h77);
      w(A_DWELL, 32'h4);
      ots_host_i.cmd(C_SAVE);
      wait_cyc(3);
      chk(saves, 0);
      ots_host_i.cmd(C_ARM);
      ots_host_i.cmd(C_TRIG);
      wait_cyc(2 * TICK_CYC);
      chk(out_vals[1], 16'h11);
      chk(out_vals[2], 16'h77);
      wait_cyc(4 * TICK_CYC);
      chk(out_vals[1], 16'h22);
      wait_cyc(14 * TICK_CYC);
      chk(out_vals[1], 16'h33);
      chk(out_vals[2], 16'h77);
      rchk(A_STAT, 32'h102);
      ots_host_i.cmd(C_SAVE);
      wait_cyc(3);
      chk(saves, 1);
      w(A_LCNT, 32'h2);
      ots_host_i.cmd(C_GRST);
      rchk(A_MODE, 32'h0);
      rchk(A_LCNT, 32'h1);
   endtask : t_list
   task automatic t_advance();
      w(A_MODE, 32'h3C);
      w(A_CFG, 32'h3);
      ots_host_i.cmd(C_ARM);
      ots_host_i.cmd(C_TRIG);
      ots_host_i.cmd(C_TRIG);
      wait_cyc(2 * TICK_CYC);
      chk(out_vals[1], 16'h11);
      wait_cyc(4 * TICK_CYC);
      chk(out_vals[1], 16'h11);
      rchk(A_STAT, 32'h2002);
      ots_host_i.cmd(C_TRIG);
      wait_cyc(3);
      chk(out_vals[1], 16'h22);
      chk(out_vals[2], 16'h77);
      wait_cyc(6 * TICK_CYC);
      ots_host_i.cmd(C_TRIG);
      wait_cyc(6 * TICK_CYC);
      chk(out_vals[1], 16'h33);
      rchk(A_STAT, 32'h202);
      ots_host_i.cmd(C_ABORT);
      rchk(A_STAT, 32'h102);
      ots_host_i.cmd(C_DCLR);
      rchk(A_MODE, 32'h0);
      chk(out_vals[1], 16'h0);
      ots_host_i.cmd(C_LCLR);
      lists_local <= 1'b1;
      ots_host_i.cmd(C_SAVE);
      wait_cyc(3);
      chk(saves, 2);
      w(A_MODE, 32'h3C);
      w(A_LIST + 8'h1, 32'h5);
      w(A_LIST + 8'h1, 32'h6);
      w(A_DWELL, 32'h4);
      ots_host_i.cmd(C_ARM);
      rchk(A_STAT, 32'h101);
   endtask : t_advance
   task automatic wrap_up();
      if (errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #(40000 * 8);
      errors++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_coupling();
      t_step();
      t_pulse();
      t_list();
      t_advance();
      wrap_up();
   end
endmodule : output_transient_sequencer_tb
`default_nettype wire
